/* File: core/lhsp_host_port.sv */
/*
 * host serial front end of a segment lcd driver: two-wire slave
 * (oversampled on clk) or three-wire link (clocked by scl itself),
 * control byte decoding, command and display ram byte delivery.
 * assumes: three_wire and address_strap_pin are static straps, the
 * command decoder loads the data pointer through ptr_load, and the
 * board resolves sda from sda_oe and sdio from sdio_oe.
 */
`timescale 1ns/100ps
module lhsp_host_port
    import lhsp_pkg::*;
(
    input wire logic clk, // core clock
    input wire logic arst_n, // async reset, active low
    input wire logic three_wire, // 1 selects the three-wire link
    input wire logic address_strap_pin, // two-wire address bit
    input wire logic [1:0] mux_mode, // lhsp_mux_e drive mode
    input wire logic [7:0] temperature_byte, // readout value
    input wire logic ptr_load, // load data pointer
    input wire logic [5:0] ptr_value, // new data pointer
    input wire logic scl, // two-wire clock, three-wire link clock
    input wire logic sda_i, // two-wire data in
    output logic sda_o, // two-wire data out, always low
    output logic sda_oe, // pull sda low
    input wire logic ce_n, // three-wire chip enable
    input wire logic sdio_i, // three-wire data in
    output logic sdio_o, // three-wire data out
    output logic sdio_oe, // three-wire drive enable
    output logic cmd_valid, // command byte pulse
    output logic [7:0] cmd_data, // command byte
    output logic ram_we, // display ram write pulse
    output logic [5:0] ram_addr, // display ram column
    output logic [7:0] ram_data // display ram byte
);
    // ****************************************
    // shared decoding
    // ****************************************
    function automatic logic [5:0] step_of(input logic [1:0] m);
        step_of = (m == LHSP_STATIC) ? STEP_STATIC :
                  (m == LHSP_MUX2) ? STEP_MUX2 : STEP_MUX4;
    endfunction : step_of

    // ****************************************
    // pin synchronisers (scl, sda, ce_n)
    // ****************************************
    logic [2:0] in_s1_q, in_s2_q;
    logic [1:0] in_s3_q;
    // two flops per pin, third keeps scl and sda history
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            in_s1_q <= 3'h7;
            in_s2_q <= 3'h7;
            in_s3_q <= 2'h3;
        end else begin
            in_s1_q <= {ce_n, sda_i, scl};
            in_s2_q <= in_s1_q;
            in_s3_q <= in_s2_q[1:0];
        end
    end

    wire scl_s = in_s2_q[0];
    wire sda_s = in_s2_q[1];
    wire ce_s = in_s2_q[2];
    wire tw_on = !three_wire;
    wire scl_rise = tw_on && scl_s && !in_s3_q[0];
    wire scl_fall = tw_on && !scl_s && in_s3_q[0];
    // start and stop while scl high
    wire tw_start = tw_on && scl_s && in_s3_q[0] && in_s3_q[1] && !sda_s;
    wire tw_stop = tw_on && scl_s && in_s3_q[0] && !in_s3_q[1] && sda_s;

    // ****************************************
    // two-wire slave
    // ****************************************
    lhsp_tw_e ist_q;
    logic [6:0] i_sh_q;
    logic [2:0] i_cnt_q;
    logic i_rw_q, i_ph_q, sda_oe_q;
    logic [7:0] i_tx_q;
    wire [7:0] i_byte = {i_sh_q, sda_s};
    wire cnt_end = i_cnt_q == BIT_LAST;
    // strap pin forms the low address bit
    wire addr_hit = i_byte[7:1] == {TW_ADDR_TOP, address_strap_pin};
    // only a full eighth bit makes a byte
    wire i_byte_v = scl_rise && ist_q == I_WR && cnt_end;

    // data taken only on scl edges
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ist_q <= I_IDLE;
            i_sh_q <= 7'h00;
            i_cnt_q <= 3'h0;
            i_rw_q <= 1'b0;
            i_ph_q <= 1'b0;
            i_tx_q <= 8'h00;
            sda_oe_q <= 1'b0;
        end else if (tw_start) begin
            ist_q <= I_ADDR;
            i_cnt_q <= 3'h0;
            i_ph_q <= 1'b0;
            sda_oe_q <= 1'b0;
        end else if (tw_stop) begin
            ist_q <= I_IDLE;
            sda_oe_q <= 1'b0;
        end else begin
            unique case (ist_q)
                I_IDLE, I_SKIP: begin
                    sda_oe_q <= 1'b0;
                end
                I_ADDR, I_WR: begin
                    if (scl_rise) begin
                        i_sh_q <= i_byte[6:0];
                        i_cnt_q <= i_cnt_q + 3'h1;
                    end
                    if (scl_rise && cnt_end) begin
                        if (ist_q == I_WR || addr_hit) begin
                            ist_q <= I_ACK;
                        end else begin
                            ist_q <= I_SKIP;
                        end
                        if (ist_q == I_ADDR) begin
                            i_rw_q <= i_byte[ADDR_RW_BIT];
                        end
                    end
                end
                I_ACK: begin
                    if (scl_fall && !i_ph_q) begin
                        sda_oe_q <= 1'b1;
                        i_ph_q <= 1'b1;
                    end else if (scl_fall) begin
                        i_ph_q <= 1'b0;
                        i_cnt_q <= 3'h0;
                        ist_q <= i_rw_q ? I_RD : I_WR;
                        sda_oe_q <= i_rw_q && !temperature_byte[7];
                        i_tx_q <= temperature_byte;
                    end
                end
                I_RD: begin
                    if (scl_fall && cnt_end) begin
                        ist_q <= I_RACK;
                        sda_oe_q <= 1'b0;
                    end else if (scl_fall) begin
                        i_tx_q <= {i_tx_q[6:0], 1'b0};
                        sda_oe_q <= !i_tx_q[6];
                        i_cnt_q <= i_cnt_q + 3'h1;
                    end
                end
                I_RACK: begin
                    if (scl_rise) begin
                        i_ph_q <= !sda_s;
                    end else if (scl_fall) begin
                        ist_q <= i_ph_q ? I_RD : I_SKIP;
                        sda_oe_q <= i_ph_q && !temperature_byte[7];
                        i_tx_q <= temperature_byte;
                        i_cnt_q <= 3'h0;
                        i_ph_q <= 1'b0;
                    end
                end
                default: begin
                    ist_q <= I_IDLE;
                    sda_oe_q <= 1'b0;
                end
            endcase
        end
    end

    // ****************************************
    // three-wire link, scl domain
    // ****************************************
    // chip enable high holds link in reset
    wire spi_rst_n = arst_n && !ce_n && three_wire;
    logic [6:0] s_sh_q, s_tx_q;
    logic [2:0] s_cnt_q;
    logic s_first_q, s_ign_q, s_rd_q, s_go_q, s_sdo_q, s_tog_q;
    logic [7:0] s_byte_q, temp_hold_q;
    wire [7:0] s_byte = {s_sh_q[6:0], sdio_i};
    wire s_end = s_cnt_q == BIT_LAST;

    always_ff @(posedge scl or negedge spi_rst_n) begin
        if (!spi_rst_n) begin
            s_sh_q <= 7'h00;
            s_cnt_q <= 3'h0;
            s_first_q <= 1'b1;
            s_ign_q <= 1'b0;
            s_rd_q <= 1'b0;
        end else begin
            // msb first, eight bits a unit
            s_sh_q <= s_byte[6:0];
            s_cnt_q <= s_cnt_q + 3'h1;
            if (s_end && s_first_q) begin
                s_first_q <= 1'b0;
                if (s_byte[SUB_SEL_HI:SUB_SEL_LO] != UNIT_SELECT_MATCH) begin
                    s_ign_q <= 1'b1;
                end else begin
                    s_rd_q <= s_byte[SUB_RW_BIT];
                end
            end
        end
    end

    // byte hand-off toggle, kept across frames
    always_ff @(posedge scl or negedge arst_n) begin
        if (!arst_n) begin
            s_tog_q <= 1'b0;
            s_byte_q <= 8'h00;
        end else if (!ce_n && s_end && !s_first_q && !s_ign_q && !s_rd_q) begin
            // write bytes after a matching subaddress go to decoder
            s_byte_q <= s_byte;
            s_tog_q <= !s_tog_q;
        end
    end

    // output bits launched on scl fall
    always_ff @(negedge scl or negedge spi_rst_n) begin
        if (!spi_rst_n) begin
            s_go_q <= 1'b0;
            s_sdo_q <= 1'b0;
            s_tx_q <= 7'h00;
        end else if (s_rd_q && !s_go_q) begin
            s_go_q <= 1'b1;
            s_sdo_q <= temp_hold_q[7];
            s_tx_q <= temp_hold_q[6:0];
        end else if (s_go_q) begin
            s_sdo_q <= s_tx_q[6];
            s_tx_q <= {s_tx_q[5:0], 1'b0};
        end
    end

    // ****************************************
    // clk side of the crossing
    // ****************************************
    logic [2:0] tog_q;
    // temperature frozen while a frame is open
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tog_q <= 3'h0;
            temp_hold_q <= 8'h00;
        end else begin
            tog_q <= {tog_q[1:0], s_tog_q};
            if (ce_s) begin
                temp_hold_q <= temperature_byte;
            end
        end
    end

    wire s_byte_v = three_wire && (tog_q[2] ^ tog_q[1]);
    wire byte_v = three_wire ? s_byte_v : i_byte_v;
    wire [7:0] byte_d = three_wire ? s_byte_q : i_byte;
    wire frame_rst = three_wire ? ce_s : tw_start;

    // ****************************************
    // control byte decoder and data pointer
    // ****************************************
    logic need_ctrl_q, cont_q, target_q;
    logic [5:0] ptr_q;
    logic cmd_v_q, ram_we_q;
    logic [7:0] cmd_d_q, ram_d_q;
    logic [5:0] ram_a_q;
    wire is_pay = byte_v && !need_ctrl_q;
    wire [6:0] ptr_sum = {1'b0, ptr_q} + {1'b0, step_of(mux_mode)};
    // stop at the row end, never wrap
    wire [5:0] ptr_next = (ptr_sum >= {1'b0, RAM_COLS}) ? RAM_COLS : ptr_sum[5:0];
    wire ram_go = is_pay && target_q && ptr_q < RAM_COLS;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            need_ctrl_q <= 1'b1;
            cont_q <= 1'b0;
            target_q <= 1'b0;
            ptr_q <= PTR_RST;
            cmd_v_q <= 1'b0;
            ram_we_q <= 1'b0;
            cmd_d_q <= 8'h00;
            ram_d_q <= 8'h00;
            ram_a_q <= PTR_RST;
        end else begin
            cmd_v_q <= is_pay && !target_q;
            ram_we_q <= ram_go;
            if (frame_rst) begin
                // first byte of an access is control
                need_ctrl_q <= 1'b1;
            end else if (byte_v && need_ctrl_q) begin
                need_ctrl_q <= 1'b0;
                cont_q <= byte_d[CTRL_CONT_BIT];
                target_q <= byte_d[CTRL_TGT_BIT];
            end else if (is_pay) begin
                // one payload then new control when flagged
                need_ctrl_q <= cont_q;
            end
            if (is_pay && !target_q) begin
                cmd_d_q <= byte_d;
            end
            if (ram_go) begin
                ram_d_q <= byte_d;
                ram_a_q <= ptr_q;
            end
            if (ptr_load) begin
                ptr_q <= ptr_value;
            end else if (ram_go) begin
                ptr_q <= ptr_next;
            end
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    // sda only pulled low, never driven high
    assign sda_o = 1'b0;
    assign sda_oe = sda_oe_q;
    // enable cleared by chip enable reset
    assign sdio_oe = s_rd_q;
    assign sdio_o = s_sdo_q;
    assign cmd_valid = cmd_v_q;
    assign cmd_data = cmd_d_q;
    assign ram_we = ram_we_q;
    assign ram_addr = ram_a_q;
    assign ram_data = ram_d_q;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    property p_start;
        tw_start |=> ist_q == I_ADDR && !sda_oe_q;
    endproperty
    a_start: assert property (p_start) else $error("start not taken");
    property p_ack;
        ist_q == I_ACK && scl_fall && !i_ph_q |=> sda_oe_q && ist_q == I_ACK;
    endproperty
    a_ack: assert property (p_ack) else $error("no acknowledge");
    property p_drive;
        sda_oe_q |-> ist_q == I_ACK || ist_q == I_RD;
    endproperty
    a_drive: assert property (p_drive) else $error("sda driven outside slot");
    property p_skip;
        scl_rise && ist_q == I_ADDR && cnt_end && !addr_hit && !tw_start && !tw_stop
            |=> ist_q == I_SKIP ##1 !sda_oe_q;
    endproperty
    a_skip: assert property (p_skip) else $error("foreign address taken");
    property p_temp;
        ist_q == I_ACK && i_ph_q && i_rw_q && scl_fall && !tw_start && !tw_stop
            |=> ist_q == I_RD && sda_oe_q == !$past(temperature_byte[7]);
    endproperty
    a_temp: assert property (p_temp) else $error("temperature msb wrong");
    property p_last;
        byte_v && need_ctrl_q && !byte_d[CTRL_CONT_BIT] && !frame_rst
            |=> !need_ctrl_q;
    endproperty
    a_last: assert property (p_last) else $error("payload after last control");
    property p_target;
        byte_v && need_ctrl_q && !frame_rst |=> target_q == $past(byte_d[CTRL_TGT_BIT]);
    endproperty
    a_target: assert property (p_target) else $error("target not latched");
    property p_store;
        ram_go |=> ram_we && ram_addr == $past(ptr_q) && ram_data == $past(byte_d);
    endproperty
    a_store: assert property (p_store) else $error("ram write lost");
    property p_step;
        ram_go && !ptr_load |=> ptr_q == $past(ptr_next) && ptr_q <= RAM_COLS;
    endproperty
    a_step: assert property (p_step) else $error("pointer step wrong");

    c_ram: cover property (ram_we ##[1:300] ram_we);
    c_cmd: cover property (cmd_valid ##[1:300] ram_we);
    c_read: cover property (ist_q == I_RD ##[1:1000] ist_q == I_RACK);
endmodule : lhsp_host_port

/* File: core/lhsp_pkg.sv */
/*
 * constants and types of the lcd driver host serial port:
 * link addresses, control byte fields, display column stepping, states.
 * assumes nothing beyond a systemverilog compiler.
 */
package lhsp_pkg;
    // ****************************************
    // link addressing
    // ****************************************
    localparam logic [5:0] TW_ADDR_TOP = 6'h1C; // upper six address bits 011100
    localparam logic [1:0] UNIT_SELECT_MATCH = 2'h1; // three-wire unit select value
    localparam int SUB_RW_BIT = 7;
    localparam int SUB_SEL_HI = 6;
    localparam int SUB_SEL_LO = 5;
    localparam int ADDR_RW_BIT = 0;

    // ****************************************
    // control byte fields
    // ****************************************
    localparam int CTRL_CONT_BIT = 7;
    localparam int CTRL_TGT_BIT = 6;

    // ****************************************
    // display data pointer
    // ****************************************
    localparam logic [5:0] RAM_COLS = 6'h2C; // 44 columns, pointer stops here
    localparam logic [5:0] PTR_RST = 6'h00;
    localparam logic [5:0] STEP_STATIC = 6'h08;
    localparam logic [5:0] STEP_MUX2 = 6'h04;
    localparam logic [5:0] STEP_MUX4 = 6'h02;
    localparam logic [2:0] BIT_LAST = 3'h7;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [1:0] {
        LHSP_STATIC = 2'h0,
        LHSP_MUX2 = 2'h1,
        LHSP_MUX4 = 2'h2
    } lhsp_mux_e;

    typedef enum logic [2:0] {
        I_IDLE = 3'h0,
        I_ADDR = 3'h1,
        I_ACK = 3'h3,
        I_WR = 3'h2,
        I_RD = 3'h6,
        I_RACK = 3'h7,
        I_SKIP = 3'h5
    } lhsp_tw_e;
endpackage : lhsp_pkg

/* File: tb/lhsp_host_model.sv */
/*
 * host bus master model: two-wire master and three-wire link master.
 * assumes clk from the bench; resolves sda (pull-up) and sdio here.
 */
`timescale 1ns/100ps
module lhsp_host_model (
    input wire logic clk, // core clock, paces two-wire timing
    input wire logic sda_oe, // device pulls sda low
    input wire logic sdio_o, // device data out
    input wire logic sdio_oe, // device drives sdio
    output logic scl, // bus clock
    output logic sda_i, // resolved sda level
    output logic ce_n, // chip enable, active low
    output logic sdio_i // resolved sdio level
);
    logic sda_low = 1'b0; // host pulls sda low
    logic h_oe = 1'b1; // host drives sdio
    logic h_d = 1'b0; // host sdio value

    // wire levels: sda pulled up, undriven sdio shows the inverse
    assign sda_i = ~(sda_oe | sda_low);
    assign sdio_i = sdio_oe ? sdio_o : (h_oe ? h_d : ~sdio_o);

    // idle bus
    initial begin
        scl = 1'b1;
        ce_n = 1'b1;
    end

    // ********************
    // bus tasks
    // ********************
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    // scl idles high on two-wire, still low on three-wire
    task automatic set_mode(input logic tw);
        scl <= ~tw;
        ce_n <= 1'b1;
    endtask : set_mode

    task automatic i2c_start();
        sda_low <= 1'b0;
        tick(6);
        scl <= 1'b1;
        tick(8);
        sda_low <= 1'b1;
        tick(8);
        scl <= 1'b0;
        tick(2);
    endtask : i2c_start

    task automatic i2c_stop();
        sda_low <= 1'b1;
        tick(6);
        scl <= 1'b1;
        tick(8);
        sda_low <= 1'b0;
        tick(8);
    endtask : i2c_stop

    task automatic i2c_bit(input logic v, output logic s);
        sda_low <= ~v;
        tick(6);
        scl <= 1'b1;
        tick(4);
        s = sda_i;
        tick(4);
        scl <= 1'b0;
        tick(2);
    endtask : i2c_bit

    task automatic i2c_byte(input logic [7:0] b, input logic ack_in,
                            output logic [7:0] r, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            i2c_bit(b[i], r[i]);
        end
        i2c_bit(ack_in, ack);
    endtask : i2c_byte

    // frame opens off the clk edges
    task automatic spi_open();
        @(posedge clk);
        #1;
        ce_n <= 1'b0;
        h_oe <= 1'b1;
        #16;
    endtask : spi_open

    task automatic spi_bits(input logic [7:0] b, input int n, output logic [7:0] r);
        r = 8'h00;
        for (int i = 7; i > 7 - n; i--) begin
            h_d <= b[i];
            #16;
            r[i] = sdio_i;
            scl <= 1'b1;
            #16;
            scl <= 1'b0;
        end
    endtask : spi_bits

    // host lets go of sdio for a read
    task automatic spi_release();
        h_oe <= 1'b0;
    endtask : spi_release

    task automatic spi_close();
        #16;
        ce_n <= 1'b1;
        h_oe <= 1'b1;
        #16;
    endtask : spi_close
endmodule : lhsp_host_model

/* File: tb/tb.sv */
/*
 * self-checking bench of the host serial port: writes, reads and foreign
 * addresses on both links, cut frames on the three-wire link.
 * assumes lhsp_host_model as the bus master and lhsp_pkg constants.
 */
`timescale 1ns/100ps
module tb
    import lhsp_pkg::*;
;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic three_wire = 1'b0;
    logic strap = 1'b0;
    logic [1:0] mux_mode = LHSP_STATIC;
    logic [7:0] temp = 8'h00;
    logic ptr_load = 1'b0;
    logic [5:0] ptr_value = 6'h00;
    logic scl, sda_i, sda_o, sda_oe, ce_n, sdio_i, sdio_o, sdio_oe;
    logic cmd_valid, ram_we;
    logic [7:0] cmd_data, ram_data;
    logic [5:0] ram_addr;
    logic [7:0] cmd_q[$];
    logic [13:0] ram_q[$];
    int miscompares = 0;
    int n_checks = 0;

    // clock
    initial forever #2 clk = ~clk;

    lhsp_host_port i_lhsp_host_port (.clk(clk), .arst_n(arst_n),
        .three_wire(three_wire), .address_strap_pin(strap), .mux_mode(mux_mode),
        .temperature_byte(temp), .ptr_load(ptr_load), .ptr_value(ptr_value),
        .scl(scl), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .ce_n(ce_n),
        .sdio_i(sdio_i), .sdio_o(sdio_o), .sdio_oe(sdio_oe),
        .cmd_valid(cmd_valid), .cmd_data(cmd_data), .ram_we(ram_we),
        .ram_addr(ram_addr), .ram_data(ram_data));

    lhsp_host_model i_lhsp_host_model (.clk(clk), .sda_oe(sda_oe),
        .sdio_o(sdio_o), .sdio_oe(sdio_oe), .scl(scl), .sda_i(sda_i),
        .ce_n(ce_n), .sdio_i(sdio_i));

    // collect delivered command and display bytes
    always @(posedge clk) begin
        if (cmd_valid === 1'b1) cmd_q.push_back(cmd_data);
        if (ram_we === 1'b1) ram_q.push_back({ram_addr, ram_data});
    end

    // ********************
    // helpers
    // ********************
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic pop_cmd(input logic [7:0] e);
        check(16'(cmd_q.size() > 0), 16'h1, "command count");
        if (cmd_q.size() > 0) check(16'(cmd_q.pop_front()), 16'(e), "command byte");
    endtask : pop_cmd

    task automatic pop_ram(input logic [13:0] e);
        check(16'(ram_q.size() > 0), 16'h1, "ram write count");
        if (ram_q.size() > 0) check(16'(ram_q.pop_front()), 16'(e), "ram column and byte");
    endtask : pop_ram

    task automatic none_left();
        repeat (12) @(posedge clk);
        check(16'(cmd_q.size()), 16'h0, "extra commands");
        check(16'(ram_q.size()), 16'h0, "extra ram writes");
    endtask : none_left

    task automatic do_reset(input logic tw, input logic st);
        arst_n <= 1'b0;
        three_wire <= tw;
        strap <= st;
        i_lhsp_host_model.set_mode(tw);
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        repeat (5) @(posedge clk);
        cmd_q.delete();
        ram_q.delete();
    endtask : do_reset

    task automatic load_ptr(input logic [5:0] v);
        ptr_value <= v;
        ptr_load <= 1'b1;
        @(posedge clk);
        ptr_load <= 1'b0;
        @(posedge clk);
    endtask : load_ptr

    task automatic i2c_wr(input logic [7:0] b, input logic ack_exp);
        logic [7:0] r;
        logic a;
        i_lhsp_host_model.i2c_byte(b, 1'b1, r, a);
        check(16'(a), 16'(ack_exp), "two-wire acknowledge");
    endtask : i2c_wr

    // whole bytes first, the last one may be cut short
    task automatic spi_wr(input logic [39:0] w, input int nbits);
        logic [7:0] r;
        i_lhsp_host_model.spi_open();
        for (int k = 0; k < nbits; k += 8) begin
            i_lhsp_host_model.spi_bits(w[39 - k -: 8], (nbits - k < 8) ? nbits - k : 8, r);
        end
        i_lhsp_host_model.spi_close();
        repeat (12) @(posedge clk);
    endtask : spi_wr

    // ********************
    // scenarios
    // ********************
    task automatic t_i2c_mixed();
        mux_mode <= LHSP_MUX2;
        load_ptr(6'h04);
        i_lhsp_host_model.i2c_start();
        i2c_wr(8'h70, 1'b0);
        i2c_wr(8'h80, 1'b0);
        i2c_wr(8'h11, 1'b0);
        i2c_wr(8'hC0, 1'b0);
        i2c_wr(8'hAA, 1'b0);
        i2c_wr(8'h40, 1'b0);
        i2c_wr(8'h55, 1'b0);
        i2c_wr(8'h42, 1'b0);
        i_lhsp_host_model.i2c_stop();
        repeat (6) @(posedge clk);
        pop_cmd(8'h11);
        pop_ram({6'h04, 8'hAA});
        pop_ram({6'h08, 8'h55});
        pop_ram({6'h0C, 8'h42});
        none_left();
    endtask : t_i2c_mixed

    task automatic t_i2c_foreign();
        i_lhsp_host_model.i2c_start();
        i2c_wr(8'h78, 1'b1);
        i_lhsp_host_model.i2c_start();
        i2c_wr(8'h72, 1'b1);
        i2c_wr(8'hC0, 1'b1);
        i2c_wr(8'h77, 1'b1);
        i_lhsp_host_model.i2c_stop();
        none_left();
    endtask : t_i2c_foreign

    task automatic t_i2c_read();
        logic [7:0] r;
        logic a;
        do_reset(1'b0, 1'b1);
        temp <= 8'h5C;
        i_lhsp_host_model.i2c_start();
        i2c_wr(8'h72, 1'b0);
        i2c_wr(8'h00, 1'b0);
        i2c_wr(8'h66, 1'b0);
        i_lhsp_host_model.i2c_start();
        i2c_wr(8'h73, 1'b0);
        i_lhsp_host_model.i2c_byte(8'hFF, 1'b0, r, a);
        check(16'(r), 16'h005C, "first temperature read");
        i_lhsp_host_model.i2c_byte(8'hFF, 1'b1, r, a);
        check(16'(r), 16'h005C, "second temperature read");
        repeat (6) @(posedge clk);
        check(16'(sda_oe), 16'h0000, "sda release after nack");
        i_lhsp_host_model.i2c_stop();
        pop_cmd(8'h66);
        none_left();
    endtask : t_i2c_read

    task automatic t_spi_steps();
        logic [5:0] s;
        for (int m = 0; m < 3; m++) begin
            s = (m == 0) ? STEP_STATIC : (m == 1) ? STEP_MUX2 : STEP_MUX4;
            mux_mode <= 2'(m);
            load_ptr(6'(RAM_COLS - 2 * s));
            spi_wr({8'h20, 8'h40, 8'hA5, 8'h3C, 8'hC3}, 40);
            pop_ram({6'(RAM_COLS - 2 * s), 8'hA5});
            pop_ram({6'(RAM_COLS - s), 8'h3C});
            none_left();
        end
    endtask : t_spi_steps

    task automatic t_spi_bad();
        for (int k = 0; k < 3; k++) begin
            spi_wr({1'b0, 2'(k + 2), 5'h00, 8'h00, 8'h99, 16'h0000}, 24);
            none_left();
        end
    endtask : t_spi_bad

    task automatic t_spi_partial();
        spi_wr({8'h20, 8'h00, 8'h12, 8'h34, 8'h00}, 28);
        pop_cmd(8'h12);
        none_left();
        spi_wr({8'h3F, 8'h00, 8'h56, 16'h0000}, 24);
        pop_cmd(8'h56);
        none_left();
    endtask : t_spi_partial

    task automatic t_spi_read();
        logic [7:0] r;
        temp <= 8'hB6;
        repeat (8) @(posedge clk);
        for (int k = 0; k < 2; k++) begin
            i_lhsp_host_model.spi_open();
            i_lhsp_host_model.spi_bits(8'hA0, 8, r);
            check(16'(sdio_oe), 16'h0001, "sdio driven after subaddress");
            i_lhsp_host_model.spi_release();
            i_lhsp_host_model.spi_bits(8'h00, 8, r);
            check(16'(r), 16'h00B6, "three-wire temperature read");
            i_lhsp_host_model.spi_close();
            check(16'(sdio_oe), 16'h0000, "sdio released at frame end");
        end
        none_left();
    endtask : t_spi_read

    task automatic final_report();
        if (miscompares == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : final_report

    // main sequence
    initial begin
        do_reset(1'b0, 1'b0);
        t_i2c_mixed();
        t_i2c_foreign();
        t_i2c_read();
        do_reset(1'b1, 1'b0);
        t_spi_steps();
        t_spi_bad();
        t_spi_partial();
        t_spi_read();
        final_report();
    end

    // watchdog, well past the expected run
    initial begin
        #100000;
        miscompares++;
        final_report();
    end
endmodule : tb
